// file: design/gcio_map.svh
// Purpose: register offsets, field layout and reset values of the pin change and drive block
// Assumes: word-aligned byte offsets on a 32-bit register port
// Notes: the disable offset comes from the register map next to the enable register
`ifndef GCIO_MAP_SVH
`define GCIO_MAP_SVH

`define GCIO_ADDR_W 8
`define GCIO_PINS 32
`define GCIO_OFS_IRQ_ENABLE 8'h40
`define GCIO_OFS_IRQ_DISABLE 8'h44
`define GCIO_OFS_IRQ_MASK_STATUS 8'h48
`define GCIO_OFS_PIN_CHANGE_STATUS 8'h4c
`define GCIO_OFS_OPEN_DRAIN_SET 8'h50
`define GCIO_OFS_OPEN_DRAIN_CLEAR 8'h54
`define GCIO_OFS_OPEN_DRAIN_STATUS 8'h58
`define GCIO_RST_MASK 32'h00000000
`define GCIO_RST_CHANGE 32'h00000000
`define GCIO_RST_OPEN_DRAIN 32'h00000000
`define GCIO_RD_UNMAPPED 32'h00000000

`endif

// file: design/gcio_pkg.sv
// Purpose: shared types of the pin change and drive block
// Assumes: gcio_map.svh holds every number
// Notes: types only
`include "gcio_map.svh"
package gcio_pkg;
	typedef logic [`GCIO_PINS-1:0] gcio_word_t;
	typedef logic [`GCIO_ADDR_W-1:0] gcio_addr_t;
endpackage

// file: design/gcio_pad_if.sv
// Purpose: carries the per-pin drive request from the core to the pad stage
// Assumes: one clock domain
// Notes: the pad stage answers with drive and enable
`timescale 1ns/100ps
interface gcio_pad_if;
	gcio_pkg::gcio_word_t out_value;
	gcio_pkg::gcio_word_t out_enable;
	gcio_pkg::gcio_word_t open_drain;
	gcio_pkg::gcio_word_t pad_drive;
	gcio_pkg::gcio_word_t pad_oe;
	modport core (output out_value, output out_enable, output open_drain,
		input pad_drive, input pad_oe);
	modport pad (input out_value, input out_enable, input open_drain,
		output pad_drive, output pad_oe);
endinterface

// file: design/gcio_pad_drive.sv
// Purpose: per-pin output stage, push-pull or open drain
// Assumes: only the open-drain input is registered in the core; value and enable come straight from its ports
// Notes: combinational; the core registers the pin outputs
`timescale 1ns/100ps
`include "gcio_map.svh"
module gcio_pad_drive (
	gcio_pad_if.pad pad
);
	genvar i;
	// ------------------------------------------------------------
	// Per-pin driver
	// ------------------------------------------------------------
	generate
		for (i = 0; i < `GCIO_PINS; i++) begin : g_pin
			// Open drain only pulls low, releasing the line for a high
			assign pad.pad_drive[i] = pad.open_drain[i] ? 1'b0 : pad.out_value[i];
			assign pad.pad_oe[i] = pad.out_enable[i] &
				(~pad.open_drain[i] | ~pad.out_value[i]);
		end
	endgenerate
endmodule

// file: design/gcio_core.sv
// Purpose: pin change detection, change interrupt and open-drain drive selection
// Assumes: 20 MHz clk_sys_in, async active-high rst_in, simple strobe register port
// Notes: pin inputs are asynchronous and pass two flip-flops before edge detection
`timescale 1ns/100ps
`include "gcio_map.svh"
module gcio_core (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [`GCIO_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [`GCIO_PINS-1:0] pin_in,
	input wire logic [`GCIO_PINS-1:0] out_value_in,
	input wire logic [`GCIO_PINS-1:0] out_enable_in,
	output logic [`GCIO_PINS-1:0] pin_out,
	output logic [`GCIO_PINS-1:0] pin_oe_out,
	output logic irq_out
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	gcio_pkg::gcio_word_t pin_meta;
	gcio_pkg::gcio_word_t pin_sync;
	gcio_pkg::gcio_word_t pin_prev;
	gcio_pkg::gcio_word_t irq_mask_status;
	gcio_pkg::gcio_word_t pin_change_status;
	gcio_pkg::gcio_word_t open_drain_status;
	gcio_pkg::gcio_word_t pin_edge;
	gcio_pkg::gcio_word_t next_change;
	logic prev_valid;
	logic [1:0] sync_fill;
	gcio_pad_if pad_bus();

	// Decode a write to one offset
	function automatic logic wr_hit(input logic we, input gcio_pkg::gcio_addr_t a,
		input gcio_pkg::gcio_addr_t ofs);
		wr_hit = we && (a == ofs);
	endfunction

	// ------------------------------------------------------------
	// Pin synchroniser and edge detection
	// ------------------------------------------------------------
	// Two stages before anything looks at the pins; metastability hazard
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// Previous sample; compare only once both sync stages hold real pin levels,
	// otherwise the reset zeros against pulled-up pins look like an edge
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_prev <= '0;
			sync_fill <= 2'h0;
			prev_valid <= 1'b0;
		end else begin
			pin_prev <= pin_sync;
			sync_fill <= {sync_fill[0], 1'b1};
			prev_valid <= sync_fill[1];
		end
	end

	// Both edges count, whatever the pin direction or enable state
	assign pin_edge = prev_valid ? (pin_sync ^ pin_prev) : '0;

	// ------------------------------------------------------------
	// Change status: sticky, cleared by a read, set wins
	// ------------------------------------------------------------
	always_comb begin
		next_change = pin_change_status;
		if (reg_read_in && reg_addr_in == `GCIO_OFS_PIN_CHANGE_STATUS) begin
			next_change = '0;
		end
		next_change = next_change | pin_edge;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_change_status <= `GCIO_RST_CHANGE;
		end else begin
			pin_change_status <= next_change;
		end
	end

	// ------------------------------------------------------------
	// Interrupt enables
	// ------------------------------------------------------------
	// Enable and disable are never in one cycle; strobes are exclusive
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_mask_status <= `GCIO_RST_MASK;
		end else if (wr_hit(reg_write_in, reg_addr_in, `GCIO_OFS_IRQ_ENABLE)) begin
			irq_mask_status <= irq_mask_status | reg_wdata_in;
		end else if (wr_hit(reg_write_in, reg_addr_in, `GCIO_OFS_IRQ_DISABLE)) begin
			irq_mask_status <= irq_mask_status & ~reg_wdata_in;
		end
	end

	// Level request; read of status drops it one cycle later
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(next_change & irq_mask_status);
		end
	end

	// ------------------------------------------------------------
	// Open-drain configuration
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			open_drain_status <= `GCIO_RST_OPEN_DRAIN;
		end else if (wr_hit(reg_write_in, reg_addr_in, `GCIO_OFS_OPEN_DRAIN_SET)) begin
			open_drain_status <= open_drain_status | reg_wdata_in;
		end else if (wr_hit(reg_write_in, reg_addr_in, `GCIO_OFS_OPEN_DRAIN_CLEAR)) begin
			open_drain_status <= open_drain_status & ~reg_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Pad stage
	// ------------------------------------------------------------
	assign pad_bus.out_value = out_value_in;
	assign pad_bus.out_enable = out_enable_in;
	assign pad_bus.open_drain = open_drain_status;

	gcio_pad_drive u_pad (
		.pad(pad_bus.pad)
	);

	// Registered so the pins never glitch with the config write
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_out <= '0;
			pin_oe_out <= '0;
		end else begin
			pin_out <= pad_bus.pad_drive;
			pin_oe_out <= pad_bus.pad_oe;
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// Data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (!reg_read_in) begin
			reg_rdata_out <= '0;
		end else begin
			case (reg_addr_in)
				`GCIO_OFS_IRQ_MASK_STATUS: begin
					reg_rdata_out <= irq_mask_status;
				end
				`GCIO_OFS_PIN_CHANGE_STATUS: begin
					reg_rdata_out <= pin_change_status | pin_edge;
				end
				`GCIO_OFS_OPEN_DRAIN_STATUS: begin
					reg_rdata_out <= open_drain_status;
				end
				default: begin
					reg_rdata_out <= `GCIO_RD_UNMAPPED;
				end
			endcase
		end
	end
endmodule

// file: verification/gcio_chk.sv
// Purpose: port checker for gcio_core
// Assumes: one clock, async active-high reset
// Notes: shadows of the enable and drive words
`timescale 1ns/100ps
module gcio_chk (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire gcio_pkg::gcio_addr_t reg_addr_in,
	input wire gcio_pkg::gcio_word_t reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire gcio_pkg::gcio_word_t reg_rdata_out,
	input wire gcio_pkg::gcio_word_t pin_in,
	input wire gcio_pkg::gcio_word_t out_value_in,
	input wire gcio_pkg::gcio_word_t out_enable_in,
	input wire gcio_pkg::gcio_word_t pin_out,
	input wire gcio_pkg::gcio_word_t pin_oe_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	gcio_pkg::gcio_word_t m, od, pq;
	logic [2:0] quiet;
	logic rc;
	assign rc = reg_read_in && reg_addr_in == 8'h4c;
	// Shadows, plus a count of quiet pin cycles so clears are judged only when no edge is in flight
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			m <= '0;
			od <= '0;
			quiet <= 3'h0;
		end else begin
			if (reg_write_in && reg_addr_in == 8'h40) m <= m | reg_wdata_in;
			if (reg_write_in && reg_addr_in == 8'h44) m <= m & ~reg_wdata_in;
			if (reg_write_in && reg_addr_in == 8'h50) od <= od | reg_wdata_in;
			if (reg_write_in && reg_addr_in == 8'h54) od <= od & ~reg_wdata_in;
			quiet <= (pin_in != pq) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
		end
	end
	always_ff @(posedge clk_sys_in) pq <= pin_in;
	a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
		else $error("read data not idle");
	a_mask_read: assert property ($past(reg_read_in && reg_addr_in == 8'h48) |->
		reg_rdata_out == $past(m)) else $error("mask word wrong");
	a_od_read: assert property ($past(reg_read_in && reg_addr_in == 8'h58) |->
		reg_rdata_out == $past(od)) else $error("drive word wrong");
	a_irq_mask: assert property (irq_out |-> |(m | $past(m)))
		else $error("irq with no enable");
	a_od_drive: assert property (((pin_out | (pin_oe_out ^
		$past(out_enable_in & ~out_value_in))) & $past(od)) == 32'h0) else $error("od drive");
	a_pp_drive: assert property (((((pin_out ^ $past(out_value_in)) & $past(out_enable_in)) |
		(pin_oe_out ^ $past(out_enable_in))) & ~$past(od)) == 32'h0) else $error("pp drive");
	a_status_clear: assert property (rc && $past(rc, 2) && quiet == 3'h7 |=>
		reg_rdata_out == 32'h0) else $error("status not cleared");
	a_irq_clear: assert property (rc && quiet == 3'h7 |-> ##2 !irq_out)
		else $error("irq not dropped");
	c_irq: cover property (irq_out);
	c_seen: cover property (rc ##1 reg_rdata_out != 32'h0);
	c_od: cover property (|(od & pin_oe_out));
endmodule
bind gcio_core gcio_chk u_chk (.*);

// file: verification/gcio_pins.sv
// Purpose: pins with pull-ups and an outside low driver
// Assumes: every line has a pull-up
// Notes: an outside low wins over a high drive
`timescale 1ns/100ps
module gcio_pins (
	input wire gcio_pkg::gcio_word_t drive_in,
	input wire gcio_pkg::gcio_word_t oe_in,
	input wire gcio_pkg::gcio_word_t ext_low_in,
	output gcio_pkg::gcio_word_t level_out
);
	// Released lines float up; a shared line is low if anyone pulls it
	assign level_out = ~(ext_low_in | (oe_in & ~drive_in));
endmodule

// file: verification/gcio_change_irq_open_drain_tb.sv
// Purpose: register-level tests of gcio_core
// Assumes: 20 MHz clock, pins from gcio_pins
// Notes: waits cover the two-flop sync and registered outputs
`timescale 1ns/100ps
module gcio_change_irq_open_drain_tb;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr = 1'b0, rd = 1'b0, irq;
	gcio_pkg::gcio_addr_t addr = '0;
	gcio_pkg::gcio_word_t wdata = '0, val = '0, oen = '0, ext = '0, rdata, pin, po, poe;
	int failures = 0, n_tests = 0, cyc = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	gcio_core u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
		.pin_in(pin), .out_value_in(val), .out_enable_in(oen), .pin_out(po),
		.pin_oe_out(poe), .irq_out(irq));
	gcio_pins u_pins (.drive_in(po), .oe_in(poe), .ext_low_in(ext), .level_out(pin));
	task automatic chk(input gcio_pkg::gcio_word_t got, input gcio_pkg::gcio_word_t exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic wr_reg(input gcio_pkg::gcio_addr_t a, input gcio_pkg::gcio_word_t d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	// Data is looked at only in the one cycle it stands
	task automatic rd_chk(input gcio_pkg::gcio_addr_t a, input gcio_pkg::gcio_word_t exp);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic summarize;
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard, well above the roughly 75 cycles the run needs
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		wt(12);
		rst_in <= 1'b0;
		rd_chk(8'h48, 32'h0);
		rd_chk(8'h4c, 32'h0);
		rd_chk(8'h58, 32'h0);
		rd_chk(8'h60, 32'h0);
		wr_reg(8'h40, 32'hffffffff);
		wr_reg(8'h44, 32'h0000ffff);
		rd_chk(8'h48, 32'hffff0000);
		// Two edges each on a disabled and an enabled pin
		ext <= 32'h80000001;
		wt(2);
		ext <= 32'h0;
		wt(6);
		chk({31'h0, irq}, 32'h1);
		rd_chk(8'h4c, 32'h80000001);
		rd_chk(8'h4c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		oen <= 32'h10;
		wt(6);
		rd_chk(8'h4c, 32'h10);
		wr_reg(8'h50, 32'h30);
		wr_reg(8'h54, 32'h20);
		rd_chk(8'h58, 32'h10);
		oen <= 32'h30;
		val <= 32'h30;
		wt(3);
		chk(poe & 32'h30, 32'h20);
		chk(pin & 32'h30, 32'h30);
		ext <= 32'h10;
		wt(6);
		chk(pin & 32'h30, 32'h20);
		rd_chk(8'h4c, 32'h10);
		wr_reg(8'h44, 32'hffffffff);
		ext <= 32'h0;
		wt(6);
		chk({31'h0, irq}, 32'h0);
		rd_chk(8'h4c, 32'h10);
		summarize();
	end
endmodule
